// *** nvbsac_ctrl.sv ***
// byte store access controller: address, data and control registers
`timescale 1ns/1ps
`include "nvbsac_regs.svh"
module nvbsac_ctrl
  import nvbsac_pkg::*;
#(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned CNT_W  = 16,
  parameter int unsigned FULL_TICK = `NVB_OSC_CYCLES
)(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire nvbsac_bus_t bus_i,
  output logic [7:0]       rdata_o,
  input  wire logic        global_irq_en_i,
  input  wire logic        flash_selfprog_busy_i,
  input  wire logic        osc_tick_i,
  output logic             cpu_stall_o,
  output logic             ready_irq_o,
  output logic             mem_rd_o,
  output logic [11:0]      mem_addr_o,
  input  wire logic [7:0]  mem_rdata_i,
  output nvbsac_prog_t     prog_o,
  input  wire logic        prog_busy_i
);
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
    logic              rdy_ie;
    logic              master;
    logic              strobe;
    logic [2:0]        arm_cnt;
    logic [2:0]        stall_cnt;
    logic              rd_pend;
    nvbsac_phase_t     phase;
    logic              start;
  } nvbsac_state_t;
  nvbsac_state_t st, next_st;

  logic tmr_busy;
  logic tmr_done;
  logic wr_ctrl;
  logic wr_strobe;
  logic wr_master;
  logic wr_read;
  logic busy;
  logic [1:0] mode_q;
  logic [1:0] next_mode;

  // duration timer runs from oscillator ticks
  nvbsac_timer #(
    .CNT_W     (CNT_W),
    .FULL_TICK (FULL_TICK)
  ) u_timer (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .start_i    (st.start),
    .mode_i     (mode_q),
    .osc_tick_i (osc_tick_i),
    .busy_o     (tmr_busy),
    .done_o     (tmr_done)
  );

  // decoded control write bits
  assign wr_ctrl   = bus_i.wr && (bus_i.addr == `NVB_OFS_CONTROL);
  assign wr_strobe = wr_ctrl && bus_i.wdata[`NVB_BIT_STROBE];
  assign wr_master = wr_ctrl && bus_i.wdata[`NVB_BIT_MASTER];
  assign wr_read   = wr_ctrl && bus_i.wdata[`NVB_BIT_READ];
  assign busy      = (st.phase == NVB_PROG) || prog_busy_i;

  // register and sequencing logic
  always_comb
  begin
    next_st       = st;
    next_st.start = 1'b0;
    next_st.rd_pend = 1'b0;
    next_mode       = mode_q;
    if (st.stall_cnt != 3'h0)
      next_st.stall_cnt = st.stall_cnt - 3'h1;
    // arming window count-down
    if (st.arm_cnt != 3'h0)
    begin
      next_st.arm_cnt = st.arm_cnt - 3'h1;
      if (st.arm_cnt == 3'h1)
        next_st.master = 1'b0;
    end
    if (bus_i.wr)
    begin
      unique case (bus_i.addr)
        `NVB_OFS_ADDR_LOW:
          if (!busy)
            next_st.addr[7:0] = bus_i.wdata;
        `NVB_OFS_ADDR_HIGH:
          if (!busy)
            next_st.addr[ADDR_W-1:8] = bus_i.wdata[ADDR_W-9:0];
        `NVB_OFS_DATA:
          next_st.data = bus_i.wdata;
        `NVB_OFS_CONTROL:
        begin
          next_st.rdy_ie = bus_i.wdata[`NVB_BIT_RDY_IE];
          if (!st.strobe)
            next_mode = bus_i.wdata[`NVB_BIT_MODE_HI:`NVB_BIT_MODE_LO];
          if (wr_master && !wr_strobe)
          begin
            next_st.master  = 1'b1;
            next_st.arm_cnt = `NVB_ARM_CYCLES;
          end
          // strobe only inside window and with flash idle
          if (wr_strobe && st.master && !st.strobe &&
              !flash_selfprog_busy_i)
          begin
            next_st.strobe    = 1'b1;
            next_st.start     = 1'b1;
            next_st.master    = 1'b0;
            next_st.arm_cnt   = 3'h0;
            next_st.stall_cnt = `NVB_WR_STALL;
          end
          if (wr_read && !busy)
          begin
            next_st.rd_pend   = 1'b1;
            next_st.stall_cnt = `NVB_RD_STALL;
          end
        end
      endcase
    end
    // fetched byte lands in data register
    if (st.rd_pend)
      next_st.data = mem_rdata_i;
    if (tmr_done)
      next_st.strobe = 1'b0;
  end

  // state register; mode survives reset while the array is busy
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st.addr      <= '0;
      st.data      <= `NVB_ZERO8;
      st.rdy_ie    <= 1'b0;
      st.master    <= 1'b0;
      st.strobe    <= 1'b0;
      st.arm_cnt   <= 3'h0;
      st.stall_cnt <= 3'h0;
      st.rd_pend   <= 1'b0;
      st.phase     <= NVB_IDLE;
      st.start     <= 1'b0;
    end
    else
    begin
      st       <= next_st;
      st.phase <= next_st.strobe ? NVB_PROG : NVB_IDLE;
    end
  end

  // mode register cleared at reset only when no program runs; the timer
  // is reset with everything else, so the array busy level keeps the mode
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      if (!(tmr_busy || prog_busy_i))
        mode_q <= `NVB_MODE_RESET;
    end
    else
      mode_q <= next_mode;
  end

  // register read mux
  always_comb
  begin
    rdata_o = `NVB_ZERO8;
    unique case (bus_i.addr)
      `NVB_OFS_ADDR_LOW:  rdata_o = st.addr[7:0];
      `NVB_OFS_ADDR_HIGH: rdata_o = {4'h0, st.addr[ADDR_W-1:8]}
                                    & `NVB_ADDR_HI_MASK;
      `NVB_OFS_DATA:      rdata_o = st.data;
      `NVB_OFS_CONTROL:   rdata_o = {2'h0, mode_q, st.rdy_ie, st.master,
                                     st.strobe, 1'b0}
                                    & `NVB_CTRL_MASK;
    endcase
  end

  assign cpu_stall_o  = (st.stall_cnt != 3'h0);
  assign ready_irq_o  = st.rdy_ie && global_irq_en_i && !st.strobe;
  assign mem_rd_o     = st.rd_pend;
  assign mem_addr_o   = st.addr;
  assign prog_o.req   = st.start;
  assign prog_o.mode  = mode_q;
  assign prog_o.addr  = st.addr;
  assign prog_o.data  = st.data;

  // arming window: opens on the arming write, shuts four cycles later
  a_arm_open: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_master && !wr_strobe) |=> st.master)
    else $error("master enable not set");
  a_master_window: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_master && !wr_strobe && !st.strobe) ##1 !wr_ctrl [*4]
      |=> !st.master)
    else $error("master enable not cleared");
  a_window_start: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_strobe && st.master && !st.strobe && !flash_selfprog_busy_i)
      |=> st.start)
    else $error("armed strobe did not start");
  a_start_needs_arm: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st.start |-> $past(st.master))
    else $error("start without armed window");
  a_no_arm_start: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_strobe && !st.master) |=> !st.start)
    else $error("strobe started without master");
  a_flash_block: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_strobe && flash_selfprog_busy_i) |=> !st.start)
    else $error("start during flash programming");

  // programming run: timer start, hardware clear, stall and held fields
  a_timer_start: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st.start |=> tmr_busy)
    else $error("duration timer not started");
  a_done_clears: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    tmr_done |=> !st.strobe)
    else $error("strobe not cleared");
  a_write_stall: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(st.strobe) |-> cpu_stall_o ##1 cpu_stall_o ##1 !cpu_stall_o)
    else $error("write stall not two cycles");
  a_mode_hold: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st.strobe |=> $stable(mode_q))
    else $error("mode changed");
  a_addr_hold: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    busy |=> $stable(st.addr))
    else $error("address changed while busy");
  a_irq_level: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ready_irq_o |-> (!st.strobe && st.rdy_ie))
    else $error("irq while programming");

  // single-instruction read: launch, refusal, stall and capture
  a_read_start: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_read && !busy) |=> (st.rd_pend && cpu_stall_o))
    else $error("read not launched");
  a_read_refused: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_read && busy) |=> !st.rd_pend)
    else $error("read launched while busy");
  a_read_stall: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st.rd_pend |-> cpu_stall_o [*4] ##1 !cpu_stall_o)
    else $error("read stall not four cycles");
  a_read_data: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st.rd_pend |=> st.data == $past(mem_rdata_i))
    else $error("read data not captured");

  // register writes and reserved read-back bits
  a_addr_write: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (bus_i.wr && (bus_i.addr == `NVB_OFS_ADDR_LOW) && !busy)
      |=> (st.addr[7:0] == $past(bus_i.wdata)))
    else $error("address low not written");
  a_data_write: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (bus_i.wr && (bus_i.addr == `NVB_OFS_DATA) && !st.rd_pend)
      |=> (st.data == $past(bus_i.wdata)))
    else $error("data register not written");
  a_addr_high_zero: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (bus_i.addr == `NVB_OFS_ADDR_HIGH)
      |-> ((rdata_o & ~`NVB_ADDR_HI_MASK) == `NVB_ZERO8))
    else $error("address high upper bits not zero");
  a_ctrl_zero: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (bus_i.addr == `NVB_OFS_CONTROL)
      |-> (((rdata_o & ~`NVB_CTRL_MASK) == `NVB_ZERO8) &&
           !rdata_o[`NVB_BIT_READ]))
    else $error("control reserved bits not zero");

  c_prog_start: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    st.start);
  c_prog_done: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tmr_done);
  c_read: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    st.rd_pend);
  c_window_expire: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(st.master) && !st.start);
  c_read_refused: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_read && busy);
endmodule : nvbsac_ctrl

// *** nvbsac_ctrl_bench.sv ***
// self-checking bench for the byte store access controller
`timescale 1ns/1ps
`include "nvbsac_regs.svh"
module nvbsac_ctrl_bench;
  import nvbsac_pkg::*;
  localparam int FULL = 40;
  localparam int HALF = FULL * 1800 / 3400;
  logic         sys_clk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  nvbsac_bus_t  bus_i = '0;
  logic [7:0]   rdata_o;
  logic         global_irq_en_i = 1'b1;
  logic         flash_selfprog_busy_i = 1'b0;
  logic         osc_tick_i = 1'b0;
  logic         cpu_stall_o;
  logic         ready_irq_o;
  logic         mem_rd_o;
  logic [11:0]  mem_addr_o;
  logic [7:0]   mem_rdata_i;
  nvbsac_prog_t prog_o;
  nvbsac_prog_t last;
  logic         prog_busy_i = 1'b0;
  int           mismatches = 0;
  int           n_tests = 0;
  int           n_req = 0;
  int           n_rd = 0;

  nvbsac_ctrl #(.FULL_TICK(FULL)) i_nvbsac_ctrl (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .global_irq_en_i(global_irq_en_i),
    .flash_selfprog_busy_i(flash_selfprog_busy_i), .osc_tick_i(osc_tick_i),
    .cpu_stall_o(cpu_stall_o), .ready_irq_o(ready_irq_o),
    .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
    .mem_rdata_i(mem_rdata_i), .prog_o(prog_o), .prog_busy_i(prog_busy_i));

  // clock, oscillator tick every other cycle, array content pattern
  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) osc_tick_i <= ~osc_tick_i;
  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], 4'hF};
  endfunction : pat
  assign mem_rdata_i = pat(mem_addr_o);

  // count programming requests and array reads
  always @(posedge sys_clk_i)
  begin
    if (prog_o.req === 1'b1)
    begin
      n_req <= n_req + 1;
      last  <= prog_o;
    end
    if (mem_rd_o === 1'b1) n_rd <= n_rd + 1;
  end

  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    bus_i <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk_i);
    bus_i.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    bus_i.addr <= a;
    @(posedge sys_clk_i);
    #1 d = rdata_o;
  endtask : rd

  task automatic stalls(input int e);
    int n;
    n = 0;
    repeat (8)
    begin
      #1 if (cpu_stall_o === 1'b1) n++;
      @(posedge sys_clk_i);
    end
    chk("stall cycles", 12'(e), 12'(n));
  endtask : stalls

  task automatic t_regs;
    logic [7:0] c;
    wr(2'h1, 8'hFF); rd(2'h1, c); chk("addr high", 8'h0F, c);
    wr(2'h0, 8'hA5); rd(2'h0, c); chk("addr low", 8'hA5, c);
    wr(2'h2, 8'h3C); rd(2'h2, c); chk("data", 8'h3C, c);
    wr(2'h3, 8'hF8); rd(2'h3, c); chk("control", 8'h38, c);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(2'h3, c); chk("mode after reset", 8'h00, c);
    $display("test regs done");
  endtask : t_regs

  task automatic t_read;
    logic [7:0] c;
    int k;
    wr(2'h1, 8'h05); wr(2'h0, 8'hA3);
    k = n_rd;
    wr(2'h3, 8'h01);
    stalls(4);
    chk("read pulses", 12'(k + 1), 12'(n_rd));
    chk("array addr", 12'h5A3, mem_addr_o);
    rd(2'h2, c); chk("read data", pat(12'h5A3), c);
    rd(2'h3, c); chk("read strobe", 1'b0, c[0]);
    $display("test read done");
  endtask : t_read

  task automatic t_prog(input logic [1:0] m);
    logic [7:0] c;
    int k, r, n;
    time t0;
    wr(2'h1, 8'h07); wr(2'h0, 8'h5A); wr(2'h2, 8'hC3);
    k = n_req;
    global_irq_en_i <= 1'b0;
    wr(2'h3, {2'h0, m, 4'h8});
    wr(2'h3, {2'h0, m, 4'hC});
    wr(2'h3, {2'h0, m, 4'hE});
    t0 = $time;
    global_irq_en_i <= 1'b1;
    r = n_rd;
    stalls(2);
    chk("prog req", 12'(k + 1), 12'(n_req));
    chk("prog mode", m, last.mode);
    chk("prog addr", 12'h75A, last.addr);
    chk("prog data", 8'hC3, last.data);
    wr(2'h3, {2'h0, ~m, 4'hA});
    wr(2'h0, 8'hFF);
    wr(2'h3, {2'h0, m, 4'hB});
    rd(2'h3, c); chk("mode kept", m, c[5:4]);
    chk("strobe busy", 1'b1, c[1]);
    chk("irq busy", 1'b0, ready_irq_o);
    rd(2'h0, c); chk("addr kept", 8'h5A, c);
    chk("read refused", 12'(r), 12'(n_rd));
    rd(2'h3, c);
    while (c[1] !== 1'b0 && ($time - t0) < 200 * 50) rd(2'h3, c);
    n = int'(($time - t0) / 50);
    k = (m == 2'h0) ? 2 * FULL : 2 * HALF;
    chk("prog time", 1'b1, n >= k - 8 && n <= k + 8);
    chk("irq ready", 1'b1, ready_irq_o);
    $display("test prog mode %0d done", m);
  endtask : t_prog

  task automatic t_refuse;
    logic [7:0] c;
    int k;
    k = n_req;
    wr(2'h3, 8'h02); rd(2'h3, c);
    chk("no master", 12'(k), 12'(n_req));
    wr(2'h3, 8'h04);
    repeat (6) @(posedge sys_clk_i);
    rd(2'h3, c); chk("master cleared", 1'b0, c[2]);
    wr(2'h3, 8'h06);
    repeat (2) @(posedge sys_clk_i);
    chk("late strobe", 12'(k), 12'(n_req));
    flash_selfprog_busy_i <= 1'b1;
    wr(2'h3, 8'h04); wr(2'h3, 8'h06);
    flash_selfprog_busy_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    chk("flash busy", 12'(k), 12'(n_req));
    prog_busy_i <= 1'b1;
    k = n_rd;
    wr(2'h0, 8'h11); wr(2'h3, 8'h01);
    prog_busy_i <= 1'b0;
    rd(2'h0, c); chk("addr busy", 8'h5A, c);
    chk("read busy", 12'(k), 12'(n_rd));
    wr(2'h3, 8'h08); #1 chk("irq on", 1'b1, ready_irq_o);
    @(posedge sys_clk_i);
    global_irq_en_i <= 1'b0;
    rd(2'h3, c); chk("irq masked", 1'b0, ready_irq_o);
    $display("test refuse done");
  endtask : t_refuse

  task automatic stop_test;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_read();
    for (int m = 0; m < 4; m++) t_prog(2'(m));
    t_refuse();
    stop_test();
  end

  // watchdog against a hang
  initial
  begin
    #(4000 * 50);
    mismatches++;
    stop_test();
  end
endmodule : nvbsac_ctrl_bench

// *** nvbsac_pkg.sv ***
// types shared by the byte store access controller
package nvbsac_pkg;
  typedef enum logic [1:0] {NVB_IDLE, NVB_PROG} nvbsac_phase_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } nvbsac_bus_t;
  typedef struct packed {
    logic        req;
    logic [1:0]  mode;
    logic [11:0] addr;
    logic [7:0]  data;
  } nvbsac_prog_t;
endpackage : nvbsac_pkg

// *** nvbsac_regs.svh ***
// register offsets, field positions and timing constants of the byte store
`ifndef NVBSAC_REGS_SVH
`define NVBSAC_REGS_SVH
`define NVB_OFS_ADDR_LOW  2'h0
`define NVB_OFS_ADDR_HIGH 2'h1
`define NVB_OFS_DATA      2'h2
`define NVB_OFS_CONTROL   2'h3
`define NVB_BIT_READ      0
`define NVB_BIT_STROBE    1
`define NVB_BIT_MASTER    2
`define NVB_BIT_RDY_IE    3
`define NVB_BIT_MODE_LO   4
`define NVB_BIT_MODE_HI   5
`define NVB_MODE_ATOMIC   2'h0
`define NVB_MODE_ERASE    2'h1
`define NVB_MODE_WRITE    2'h2
`define NVB_MODE_RESET    2'h0
`define NVB_ARM_CYCLES    3'h4
`define NVB_WR_STALL      3'h2
`define NVB_RD_STALL      3'h4
`define NVB_OSC_CYCLES    26368
`define NVB_TIME_ATOMIC_US 3400
`define NVB_TIME_HALF_US   1800
`define NVB_ADDR_HI_MASK  8'h0F
`define NVB_CTRL_MASK     8'h3F
`define NVB_ZERO8         8'h00
`endif

// *** nvbsac_timer.sv ***
// programming duration timer counting oscillator tick enables
`timescale 1ns/1ps
`include "nvbsac_regs.svh"
module nvbsac_timer
  import nvbsac_pkg::*;
#(
  parameter int unsigned CNT_W     = 16,
  parameter int unsigned FULL_TICK = `NVB_OSC_CYCLES
)(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       start_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       osc_tick_i,
  output logic            busy_o,
  output logic            done_o
);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(FULL_TICK);
  // erase-only and write-only last 1.8/3.4 of an atomic cycle
  localparam logic [CNT_W-1:0] HALF =
    CNT_W'((FULL_TICK * `NVB_TIME_HALF_US) / `NVB_TIME_ATOMIC_US);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             busy;
    logic             done;
  } nvbsac_tmr_t;
  nvbsac_tmr_t st, next_st;

  // load on start, count down on each oscillator tick
  always_comb
  begin
    next_st      = st;
    next_st.done = 1'b0;
    if (start_i && !st.busy)
    begin
      next_st.busy = 1'b1;
      next_st.cnt  = (mode_i == `NVB_MODE_ATOMIC) ? FULL : HALF;
    end
    else if (st.busy && osc_tick_i)
    begin
      if (st.cnt <= CNT_W'(1))
      begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        next_st.cnt  = '0;
      end
      else
        next_st.cnt = st.cnt - CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign busy_o = st.busy;
  assign done_o = st.done;
endmodule : nvbsac_timer
